// *** inc/sbgl_consts.svh ***
// Register offsets, field positions, reset values and divider figures.
`ifndef SBGL_CONSTS_SVH
`define SBGL_CONSTS_SVH

`define SBGL_ADDR_W        8
`define SBGL_OFF_RATE      8'h00
`define SBGL_OFF_CTRL      8'h04
`define SBGL_OFF_STATUS    8'h08
`define SBGL_OFF_TXDATA    8'h0C

`define SBGL_RATE_RESET    8'h00
`define SBGL_CTRL_RESET    2'h0

`define SBGL_CTRL_TXEN     0
`define SBGL_CTRL_RXEN     1

`define SBGL_ST_STOP       0
`define SBGL_ST_WAIT       1
`define SBGL_ST_TXBUSY     2
`define SBGL_ST_RXBUSY     3
`define SBGL_ST_PEND       4
`define SBGL_ST_PORTEN     5

`define SBGL_NP_SEL0       4'h1
`define SBGL_NP_SEL1       4'h3
`define SBGL_NP_SEL2       4'h4
`define SBGL_NP_SEL3       4'hD

`define SBGL_TX_OVERSAMPLE 11'h010
`define SBGL_RX_PHASE_LAST 4'hF

`define SBGL_RESP_OKAY     2'h0
`define SBGL_RESP_SLVERR   2'h2

`endif

// *** inc/sbgl_pkg.sv ***
// Types shared by the baud generator files.
package sbgl_pkg;

    typedef struct packed {
        logic [1:0] presSel;
        logic [2:0] txSel;
        logic [2:0] rxSel;
    } sbgl_rate_t;

    typedef struct packed {
        logic rxEn;
        logic txEn;
    } sbgl_ctrl_t;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP
    } sbgl_mode_t;

endpackage

// *** rtl/sbgl_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module sbgl_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic             inValid,
    output wire logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output wire logic             outValid,
    input  wire logic             outReady,
    output wire logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [CW-1:0]    count_r;

    wire push = inValid && inReady;
    wire pop  = outValid && outReady;

    assign inReady  = (count_r != CW'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= bump(wrPtr_r);
            end
            if (pop) begin
                rdPtr_r <= bump(rdPtr_r);
            end
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end
endmodule // sbgl_buf

// *** rtl/sbgl_top.sv ***
// Baud-rate generator with stop and wait behaviour and AXI4-Lite registers.
//
// Behaviour
// - Prescaler divides processor clock by 1, 3, 4 or 13 per select.
// - Receive divider divides by two to its select; transmit divider by sixteen times that.
// - Receive tick runs sixteen times the receive baud rate.
// - Whole chain runs from the processor clock, scaling with it.
// - Stop mode halts the generator; no transmit or receive progress.
// - Transmit timing freezes in stop and resumes where it left.
// - Receive frame in progress at stop entry is aborted, not resumed.
// - Wait mode leaves generator and both directions running normally.
// - A serial interrupt condition during wait mode wakes the system.
// - Clearing both enable bits disables the port to save power.
// - One prescaler output feeds both transmit and receive dividers.
// - Transmit and receive rate selections are independent.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sbgl_consts.svh"
module sbgl_top (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // AXI4-Lite write address and data
    input  wire logic       awvalid,
    output wire logic       awready,
    input  wire logic [7:0] awaddr,
    input  wire logic       wvalid,
    output wire logic       wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output wire logic       bvalid,
    input  wire logic       bready,
    output wire logic [1:0] bresp,
    // AXI4-Lite read
    input  wire logic       arvalid,
    output wire logic       arready,
    input  wire logic [7:0] araddr,
    output wire logic       rvalid,
    input  wire logic       rready,
    output wire logic [31:0] rdata,
    output wire logic [1:0] rresp,
    // Power modes and wake-up
    input  wire logic       stopMode,
    input  wire logic       waitMode,
    input  wire logic       serialIrq,
    output wire logic       wakeReq,
    // Shifter side
    input  wire logic       txBusy,
    input  wire logic       rxBusy,
    output wire logic       txEnable,
    output wire logic       rxEnable,
    output wire logic       txTick,
    output wire logic       rxTick,
    output wire logic       rxBitTick,
    output wire logic       rxAbort,
    // Transmit byte stream
    output wire logic       txDataValid,
    input  wire logic       txDataReady,
    output wire logic [7:0] txData
);
    sbgl_pkg::sbgl_rate_t rate_r;
    sbgl_pkg::sbgl_ctrl_t ctrl_r;
    sbgl_pkg::sbgl_mode_t mode;

    logic [3:0]  presCnt_r;
    logic [10:0] txCnt_r;
    logic [6:0]  rxCnt_r;
    logic [3:0]  rxPhase_r;
    logic        stopDly_r;
    logic        rxAbort_r;
    logic        wakeReq_r;

    logic        awHeld_r;
    logic        wHeld_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // Register decode.
    wire        bothHeld  = awHeld_r && wHeld_r && !bvalid_r;
    wire        hitRate   = (awAddr_r == `SBGL_OFF_RATE);
    wire        hitCtrl   = (awAddr_r == `SBGL_OFF_CTRL);
    wire        hitTxData = (awAddr_r == `SBGL_OFF_TXDATA);
    wire        hitStatW  = (awAddr_r == `SBGL_OFF_STATUS);
    wire        wrMapped  = hitRate || hitCtrl || hitTxData || hitStatW;
    wire        lane0     = wStrb_r[0];
    wire        bufReady;
    // A data write waits for buffer room, so the stall reaches the master.
    wire        wrCommit  = bothHeld && !(hitTxData && lane0 && !bufReady);
    wire        rateWr    = wrCommit && hitRate && lane0;
    wire        ctrlWr    = wrCommit && hitCtrl && lane0;
    wire        bufPush   = wrCommit && hitTxData && lane0;

    // Divider chain.
    wire        portEn    = ctrl_r.txEn || ctrl_r.rxEn;
    wire        run       = !stopMode && portEn;
    wire        stopEnter = stopMode && !stopDly_r;
    wire [3:0]  np        = (rate_r.presSel == 2'h0) ? `SBGL_NP_SEL0 :
                            (rate_r.presSel == 2'h1) ? `SBGL_NP_SEL1 :
                            (rate_r.presSel == 2'h2) ? `SBGL_NP_SEL2 :
                                                       `SBGL_NP_SEL3;
    wire [3:0]  npLast    = np - 4'h1;
    wire [10:0] txLast    = (`SBGL_TX_OVERSAMPLE << rate_r.txSel) - 11'h001;
    wire [7:0]  nrDiv     = 8'h01 << rate_r.rxSel;
    wire [6:0]  rxLast    = 7'(nrDiv - 8'h01);
    wire        presTick  = run && (presCnt_r == npLast);
    wire        txTickInt = presTick && (txCnt_r == txLast);
    wire        rxTickInt = presTick && (rxCnt_r == rxLast);

    assign mode = stopMode ? sbgl_pkg::MODE_STOP :
                  waitMode ? sbgl_pkg::MODE_WAIT : sbgl_pkg::MODE_RUN;

    // Only the processor clock advances the chain, so slow bus mode scales
    // every rate with it. Wait mode does not enter the run term at all.
    always_ff @(posedge ref_clk) begin
        if (rst || rateWr) begin
            presCnt_r <= 4'h0;
        end else if (run) begin
            presCnt_r <= presTick ? 4'h0 : presCnt_r + 4'h1;
        end
    end

    // Transmit count holds while stopped so a frame resumes in place.
    always_ff @(posedge ref_clk) begin
        if (rst || rateWr) begin
            txCnt_r <= 11'h000;
        end else if (presTick) begin
            txCnt_r <= txTickInt ? 11'h000 : txCnt_r + 11'h001;
        end
    end

    // Receive counts restart at stop entry; the partial frame is dropped.
    always_ff @(posedge ref_clk) begin
        if (rst || rateWr || stopEnter) begin
            rxCnt_r   <= 7'h00;
            rxPhase_r <= 4'h0;
        end else if (presTick) begin
            rxCnt_r <= rxTickInt ? 7'h00 : rxCnt_r + 7'h01;
            if (rxTickInt) begin
                rxPhase_r <= rxPhase_r + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stopDly_r <= 1'b0;
            rxAbort_r <= 1'b0;
            wakeReq_r <= 1'b0;
        end else begin
            stopDly_r <= stopMode;
            rxAbort_r <= stopEnter && ctrl_r.rxEn;
            wakeReq_r <= waitMode && serialIrq;
        end
    end

    assign txTick    = txTickInt && ctrl_r.txEn;
    assign rxTick    = rxTickInt && ctrl_r.rxEn;
    assign rxBitTick = rxTick && (rxPhase_r == `SBGL_RX_PHASE_LAST);
    assign rxAbort   = rxAbort_r;
    assign wakeReq   = wakeReq_r;
    assign txEnable  = ctrl_r.txEn;
    assign rxEnable  = ctrl_r.rxEn;

    // Write channels are taken in either order and joined before the answer.
    assign awready = !awHeld_r && !bvalid_r;
    assign wready  = !wHeld_r && !bvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= 32'h00000000;
            wStrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= `SBGL_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {awaddr[7:2], 2'h0};
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (wrCommit) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wrMapped ? `SBGL_RESP_OKAY : `SBGL_RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rate_r <= `SBGL_RATE_RESET;
            ctrl_r <= `SBGL_CTRL_RESET;
        end else begin
            if (rateWr) begin
                rate_r <= wData_r[7:0];
            end
            if (ctrlWr) begin
                ctrl_r.txEn <= wData_r[`SBGL_CTRL_TXEN];
                ctrl_r.rxEn <= wData_r[`SBGL_CTRL_RXEN];
            end
        end
    end

    // Read path.
    wire [31:0] statusWord = {26'h0, portEn, txDataValid, rxBusy, txBusy,
                              mode == sbgl_pkg::MODE_WAIT,
                              mode == sbgl_pkg::MODE_STOP};
    wire [7:0]  rdAddr  = {araddr[7:2], 2'h0};
    wire        rdRate  = (rdAddr == `SBGL_OFF_RATE);
    wire        rdCtrl  = (rdAddr == `SBGL_OFF_CTRL);
    wire        rdStat  = (rdAddr == `SBGL_OFF_STATUS);
    wire        rdTxd   = (rdAddr == `SBGL_OFF_TXDATA);
    wire [31:0] rdMux   = rdRate ? {24'h0, rate_r} :
                          rdCtrl ? {30'h0, ctrl_r} :
                          rdStat ? statusWord : 32'h00000000;

    assign arready = !rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `SBGL_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdMux;
            rresp_r  <= (rdRate || rdCtrl || rdStat || rdTxd) ?
                        `SBGL_RESP_OKAY : `SBGL_RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    sbgl_buf #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_txBuf (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (bufPush),
        .inReady  (bufReady),
        .inData   (wData_r[7:0]),
        .outValid (txDataValid),
        .outReady (txDataReady),
        .outData  (txData)
    );

    // Helper logic for the checks: cycles between receive ticks.
    logic [10:0] rxGap_r;
    logic        gapValid_r;
    wire  [10:0] rxPeriod = {7'h00, np} * {3'h0, nrDiv};

    always_ff @(posedge ref_clk) begin
        if (rst || rateWr || !run) begin
            rxGap_r    <= 11'h000;
            gapValid_r <= 1'b0;
        end else if (rxTickInt) begin
            rxGap_r    <= 11'h000;
            gapValid_r <= 1'b1;
        end else begin
            rxGap_r <= rxGap_r + 11'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire sel1Run = run && !rateWr && (rate_r.presSel == 2'h1);

    sequence s_div3Gap;
        (presTick && sel1Run) ##1 (sel1Run && !presTick)[*2] ##1 sel1Run;
    endsequence

    property p_presDiv3;
        s_div3Gap |-> presTick;
    endproperty
    a_presDiv3: assert property (p_presDiv3)
        else $error("prescaler does not divide by three");

    property p_presDiv1;
        (run && !rateWr && rate_r.presSel == 2'h0) ##1 run |-> presTick;
    endproperty
    a_presDiv1: assert property (p_presDiv1)
        else $error("prescaler by one misses a cycle");

    property p_rxPeriod;
        rxTickInt && gapValid_r |-> rxGap_r == rxPeriod - 11'h001;
    endproperty
    a_rxPeriod: assert property (p_rxPeriod)
        else $error("receive tick spacing wrong");

    property p_bitTick;
        rxBitTick |-> rxTick && rxPhase_r == `SBGL_RX_PHASE_LAST
                      ##1 rxPhase_r == 4'h0;
    endproperty
    a_bitTick: assert property (p_bitTick)
        else $error("bit tick not on sixteenth receive tick");

    property p_stopHalt;
        stopMode |-> !txTick && !rxTick && !presTick;
    endproperty
    a_stopHalt: assert property (p_stopHalt)
        else $error("ticks during stop mode");

    property p_txFreeze;
        stopMode && !rateWr |=> $stable(txCnt_r);
    endproperty
    a_txFreeze: assert property (p_txFreeze)
        else $error("transmit count moved in stop");

    property p_rxDrop;
        stopEnter && ctrl_r.rxEn |=> rxAbort && rxCnt_r == 7'h00
                                  && rxPhase_r == 4'h0;
    endproperty
    a_rxDrop: assert property (p_rxDrop)
        else $error("receive frame not dropped at stop");

    property p_wake;
        waitMode && serialIrq |=> wakeReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake-up in wait mode");

    property p_portOff;
        !ctrl_r.txEn && !ctrl_r.rxEn |-> !presTick && !txTick && !rxTick;
    endproperty
    a_portOff: assert property (p_portOff)
        else $error("generator runs with port disabled");

    property p_rateClear;
        rateWr |=> presCnt_r == 4'h0 && txCnt_r == 11'h000
                   && rxCnt_r == 7'h00;
    endproperty
    a_rateClear: assert property (p_rateClear)
        else $error("counters not cleared by rate write");
endmodule // sbgl_top

// *** testbench/sbgl_far_end.sv ***
// Far-side model of the transmit shifter and of receive line activity.
`timescale 1ns/100ps
module sbgl_far_end (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Bench controls
    input  wire logic        stall,
    input  wire logic        frameOn,
    // Byte stream and bit timing
    input  wire logic        txDataValid,
    output wire logic        txDataReady,
    input  wire logic [7:0]  txData,
    input  wire logic        txTick,
    // Shifter status and observed bytes
    output wire logic        txBusy,
    output wire logic        rxBusy,
    output logic      [31:0] gotBytes,
    output logic      [7:0]  byteCnt
);
    logic busy_r;

    // A real shifter holds one byte a frame, so a stall here backs up the
    // two-entry buffer inside the block.
    assign txDataReady = !stall && !busy_r;
    assign txBusy      = busy_r;
    assign rxBusy      = frameOn;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_r   <= 1'h0;
            gotBytes <= 32'h0;
            byteCnt  <= 8'h0;
        end else if (txDataValid && txDataReady) begin
            busy_r   <= 1'h1;
            gotBytes <= {gotBytes[23:0], txData};
            byteCnt  <= byteCnt + 8'h1;
        end else if (txTick) begin
            busy_r <= 1'h0;
        end
    end
endmodule // sbgl_far_end

// *** testbench/sbgl_top_test.sv ***
// Self-checking bench for the baud generator and its power modes.
`timescale 1ns/100ps
`include "sbgl_consts.svh"
module sbgl_top_test;
    localparam logic [7:0] RT = `SBGL_OFF_RATE;
    localparam logic [7:0] CT = `SBGL_OFF_CTRL;
    localparam logic [7:0] ST = `SBGL_OFF_STATUS;
    localparam logic [7:0] TX = `SBGL_OFF_TXDATA;
    localparam logic [1:0] OK = `SBGL_RESP_OKAY;
    logic             ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic             stopMode, waitMode, serialIrq, stall, frameOn;
    logic      [7:0]  awaddr, araddr;
    logic      [31:0] wdata;
    logic      [3:0]  wstrb;
    logic      [1:0]  rs;
    wire logic        awready, wready, bvalid, arready, rvalid, wakeReq;
    wire logic        txBusy, rxBusy, txEnable, rxEnable, txTick, rxTick;
    wire logic        rxBitTick, rxAbort, txDataValid, txDataReady;
    wire logic [1:0]  bresp, rresp;
    wire logic [7:0]  txData, byteCnt;
    wire logic [31:0] rdata, gotBytes;
    int               errorCnt, testsRun, cyc, txCnt, txPer, txSeen, rxCnt;
    int               rxPer, rxSeen, bitCnt, bitPer, bitSeen, abortN, stopTk;
    int               t0;
    int               npTab[4] = '{1, 3, 4, 13};

    sbgl_top dut_u (
        .ref_clk(ref_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .stopMode(stopMode), .waitMode(waitMode), .serialIrq(serialIrq),
        .wakeReq(wakeReq), .txBusy(txBusy), .rxBusy(rxBusy),
        .txEnable(txEnable), .rxEnable(rxEnable), .txTick(txTick),
        .rxTick(rxTick), .rxBitTick(rxBitTick), .rxAbort(rxAbort),
        .txDataValid(txDataValid), .txDataReady(txDataReady),
        .txData(txData)
    );

    sbgl_far_end far_u (
        .ref_clk(ref_clk), .rst(rst), .stall(stall), .frameOn(frameOn),
        .txDataValid(txDataValid), .txDataReady(txDataReady),
        .txData(txData), .txTick(txTick), .txBusy(txBusy), .rxBusy(rxBusy),
        .gotBytes(gotBytes), .byteCnt(byteCnt)
    );

    always #5 ref_clk = ~ref_clk;

    // Transmit and receive periods count only cycles outside stop, so a frozen divider that
    // resumes in place still shows one whole period.
    always @(posedge ref_clk) begin
        cyc++;
        bitCnt++;
        if (!stopMode) begin
            txCnt++;
            rxCnt++;
        end
        if (txTick) begin
            txPer = txCnt;
            txCnt = 0;
            txSeen++;
        end
        if (rxTick) begin
            rxPer = rxCnt;
            rxCnt = 0;
            rxSeen++;
        end
        if (rxBitTick) begin
            bitPer = bitCnt;
            bitCnt = 0;
            bitSeen++;
        end
        if (stopMode && (txTick || rxTick)) stopTk++;
        if (rxAbort) abortN++;
    end

    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errorCnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chkResp(input string nm, input logic [1:0] e);
        testsRun++;
        if (rs !== e) begin
            errorCnt++;
            $display("mismatch %s resp expected %0h seen %0h", nm, e, rs);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        aw = 1'h0;
        w = 1'h0;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            if (!aw && awready) begin
                aw = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w && wready) begin
                w = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (!bvalid) @(posedge ref_clk);
        rs = bresp;
        bready <= 1'h0;
    endtask

    task automatic wrChk(string nm, logic [7:0] a, logic [31:0] d,
                         logic [1:0] e);
        wr(a, d);
        chkResp(nm, e);
    endtask

    task automatic rdChk(string nm, logic [7:0] a, logic [31:0] e,
                         logic [1:0] er);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (!rvalid);
        rs = rresp;
        chk(nm, e, rdata);
        chkResp(nm, er);
        rready <= 1'h0;
    endtask

    task automatic clr();
        #1;
        txSeen = 0;
        rxSeen = 0;
        bitSeen = 0;
        abortN = 0;
        stopTk = 0;
    endtask

    task automatic setRate(input logic [1:0] p, logic [2:0] t, logic [2:0] r);
        wrChk("rate", RT, {24'h0, p, t, r}, OK);
        clr();
    endtask

    task automatic waitTicks(input int n);
        int k;
        for (k = 0; k < 30000 && !(txSeen >= n && rxSeen >= n); k++) begin
            @(posedge ref_clk);
        end
        // A tick stream that never arrives is a failure, not a silent skip.
        if (!(txSeen >= n && rxSeen >= n)) begin
            errorCnt++;
            $display("mismatch ticks expected %0d seen %0d", n, txSeen);
        end
    endtask

    task automatic finalReport();
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #800000;
        errorCnt++;
        $display("mismatch watchdog expected finish seen timeout");
        finalReport();
    end

    initial begin
        logic [1:0] p;
        ref_clk = 1'h0;
        rst = 1'h1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {stopMode, waitMode, serialIrq, stall, frameOn} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        rdChk("rate reset", RT, 32'h0, OK);
        rdChk("ctrl reset", CT, 32'h0, OK);
        wrChk("status write", ST, 32'hFF, OK);
        rdChk("status", ST, 32'h0, OK);
        rdChk("txdata read", TX, 32'h0, OK);
        wrChk("unmapped", 8'h10, 32'h5, `SBGL_RESP_SLVERR);
        rdChk("unmapped", 8'h10, 32'h0, `SBGL_RESP_SLVERR);
        wstrb <= 4'hE;
        wrChk("rate lane", RT, 32'hFF, OK);
        rdChk("rate lane", RT, 32'h0, OK);
        wstrb <= 4'hF;
        $display("test registers done");
        wrChk("ctrl both", CT, 32'h3, OK);
        for (int i = 0; i < 8; i++) begin
            p = 2'((7 - i) % 4);
            setRate(p, 3'(i), 3'(7 - i));
            rdChk("rate", RT, {24'h0, p, 3'(i), 3'(7 - i)}, OK);
            waitTicks(2);
            chk("tx", 16 * npTab[p] * (1 << i), txPer);
            chk("rx", npTab[p] * (1 << (7 - i)), rxPer);
        end
        $display("test dividers done");
        setRate(2'h1, 3'h2, 3'h3);
        waitTicks(5);
        chk("rx bit", 384, bitPer);
        chk("tx", 192, txPer);
        clr();
        waitTicks(1);
        repeat (60) @(posedge ref_clk);
        stopMode <= 1'h1;
        frameOn  <= 1'h1;
        repeat (300) @(posedge ref_clk);
        rdChk("status stop", ST, 32'h29, OK);
        chk("ticks in stop", 0, stopTk);
        chk("rx abort", 1, abortN);
        stopMode <= 1'h0;
        frameOn  <= 1'h0;
        clr();
        waitTicks(1);
        chk("tx resume", 192, txPer);
        $display("test stop done");
        @(posedge ref_clk);
        waitMode <= 1'h1;
        clr();
        waitTicks(2);
        chk("tx wait", 192, txPer);
        chk("rx wait", 24, rxPer);
        rdChk("status wait", ST, 32'h22, OK);
        @(posedge ref_clk);
        serialIrq <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("wake", 1, wakeReq);
        @(posedge ref_clk);
        waitMode <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk("wake outside wait", 0, wakeReq);
        @(posedge ref_clk);
        serialIrq <= 1'h0;
        $display("test wait done");
        wrChk("ctrl off", CT, 32'h0, OK);
        clr();
        repeat (400) @(posedge ref_clk);
        chk("ticks off", 0, txSeen + rxSeen);
        chk("enables", 0, {txEnable, rxEnable});
        rdChk("status off", ST, 32'h0, OK);
        wrChk("ctrl tx", CT, 32'h1, OK);
        clr();
        repeat (400) @(posedge ref_clk);
        chk("rx off", 0, rxSeen);
        chk("tx on", 1, txSeen > 0);
        $display("test enables done");
        setRate(2'h0, 3'h0, 3'h0);
        wrChk("ctrl both", CT, 32'h3, OK);
        stall <= 1'h1;
        wrChk("byte 1", TX, 32'hA5, OK);
        wrChk("byte 2", TX, 32'h5A, OK);
        rdChk("status full", ST, 32'h30, OK);
        fork
            begin
                repeat (40) @(posedge ref_clk);
                stall <= 1'h0;
            end
        join_none
        t0 = cyc;
        wrChk("byte 3", TX, 32'h3C, OK);
        chk("full refuses", 1, cyc - t0 >= 40);
        repeat (200) @(posedge ref_clk);
        chk("bytes", 32'h00A55A3C, gotBytes);
        chk("byte count", 3, byteCnt);
        rdChk("status drained", ST, 32'h20, OK);
        $display("test buffer done");
        clr();
        chk("idle before stop", 0, {txBusy, rxBusy});
        @(posedge ref_clk);
        stopMode <= 1'h1;
        repeat (30) @(posedge ref_clk);
        stopMode <= 1'h0;
        chk("ticks in idle stop", 0, stopTk);
        chk("idle stop abort", 1, abortN);
        $display("test idle stop done");
        finalReport();
    end
endmodule // sbgl_top_test
